// ===== src/emb_pkg.sv
// Constants shared by the external memory bus logic
package emb_pkg;
	localparam int unsigned SYS_CLK_NS = 10;
	localparam int unsigned TCK_NS = 40;
	localparam int unsigned TCK_CYC = TCK_NS / SYS_CLK_NS;
	localparam int unsigned PH_W = 2;
	localparam logic [1:0] PH_FIRST = 2'h0;
	localparam logic [1:0] PH_SAMPLE = 2'h1;
	localparam logic [1:0] PH_HALF = 2'h2;
	localparam logic [1:0] PH_LAST = 2'h3;
	localparam int unsigned ADDR_W = 14;
	localparam int unsigned DATA_W = 24;
	localparam int unsigned WS_W = 3;
	localparam int unsigned CNT_W = 6;
	localparam logic [5:0] STB_BASE_CYC = 6'h02;
	localparam logic [5:0] TCK_CNT = 6'(TCK_CYC);
	localparam int unsigned NUM_SPACES = 3;
	localparam logic [1:0] SPACE_PROG = 2'h0;
	localparam logic [1:0] SPACE_DATA = 2'h1;
	localparam logic [1:0] SPACE_BOOT = 2'h2;
	localparam logic RST_SYNC = 1'h1;
	typedef enum logic [2:0] {
		EMB_IDLE = 3'b000,
		EMB_SETUP = 3'b001,
		EMB_STROBE = 3'b010,
		EMB_RECOV = 3'b011,
		EMB_HOLD = 3'b100,
		EMB_UNHOLD = 3'b101
	} emb_state_t;
endpackage

// ===== src/emb_sync.sv
// Two-stage level synchroniser for an asynchronous input
`timescale 1ns/1ps
`default_nettype none
module emb_sync (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= emb_pkg::RST_SYNC;
			sync_out <= emb_pkg::RST_SYNC;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ===== src/emb_bus.sv
// External memory bus with strobes, wait states and hold grant
// Behaviour
// - Hold request sampled each cycle; acted on this cycle or the next when the bus is idle, else only once the current access has ended.
// - Hold acknowledge goes low in the cycle after the request is recognized.
// - Asynchronous hold request is synchronised inside the block.
// - Selects and strobes float no later than hold acknowledge goes low.
// - Hold acknowledge rises no later than selects and strobes are driven again.
// - Write data is driven only after the write strobe has fallen.
// - Write data leads strobe rise; lead grows four input periods (one processor cycle) per wait state.
// - Write data is released before the next read or write strobe.
`timescale 1ns/1ps
`default_nettype none
module emb_bus (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic acc_req,
	input wire logic acc_write,
	input wire logic [1:0] acc_space,
	input wire logic [emb_pkg::ADDR_W-1:0] acc_addr,
	input wire logic [emb_pkg::DATA_W-1:0] acc_wdata,
	input wire logic [emb_pkg::WS_W-1:0] wait_prog,
	input wire logic [emb_pkg::WS_W-1:0] wait_data,
	input wire logic [emb_pkg::WS_W-1:0] wait_boot,
	output logic acc_done,
	output logic [emb_pkg::DATA_W-1:0] acc_rdata,
	output logic cycle_clock_out,
	input wire logic hold_request_n,
	output logic hold_ack_n,
	output logic [emb_pkg::ADDR_W-1:0] mem_addr,
	output logic [emb_pkg::NUM_SPACES-1:0] space_select_n,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic ctrl_oe,
	input wire logic [emb_pkg::DATA_W-1:0] mem_data_in,
	output logic [emb_pkg::DATA_W-1:0] mem_data_out,
	output logic mem_data_oe
);
	emb_pkg::emb_state_t state_q;
	logic [emb_pkg::PH_W-1:0] ph_q;
	logic [emb_pkg::CNT_W-1:0] cnt_q;
	logic req_sync_n;
	logic hold_seen_q;
	logic write_q;
	logic [1:0] space_q;
	logic [emb_pkg::WS_W-1:0] ws_sel;
	logic [emb_pkg::CNT_W-1:0] stb_len;
	logic start_go;
	logic grant_go;
	logic stb_end;

	// Request synchroniser
	emb_sync u_sync (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.async_in(hold_request_n),
		.sync_out(req_sync_n)
	);

	// Processor cycle phase counter and cycle clock
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ph_q <= emb_pkg::PH_FIRST;
			cycle_clock_out <= 1'b1;
		end else begin
			ph_q <= ph_q + 2'h1;
			cycle_clock_out <= (ph_q == emb_pkg::PH_LAST) || (ph_q == emb_pkg::PH_FIRST);
		end
	end

	// Hold request recognition once per processor cycle
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			hold_seen_q <= 1'b0;
		end else if (ph_q == emb_pkg::PH_SAMPLE) begin
			hold_seen_q <= ~req_sync_n;
		end
	end

	// Wait states of the requested space
	always_comb begin
		ws_sel = wait_data;
		unique case (acc_space)
			emb_pkg::SPACE_PROG: ws_sel = wait_prog;
			emb_pkg::SPACE_DATA: ws_sel = wait_data;
			emb_pkg::SPACE_BOOT: ws_sel = wait_boot;
			default: ws_sel = wait_data;
		endcase
	end

	assign stb_len = 6'(emb_pkg::STB_BASE_CYC - 6'h01 + 6'(ws_sel) * emb_pkg::TCK_CNT);
	assign grant_go = (state_q == emb_pkg::EMB_IDLE) && (ph_q == emb_pkg::PH_LAST) && hold_seen_q;
	assign start_go = (state_q == emb_pkg::EMB_IDLE) && (ph_q == emb_pkg::PH_LAST)
		&& !hold_seen_q && acc_req;
	assign stb_end = (state_q == emb_pkg::EMB_STROBE) && (cnt_q == 6'h00);

	// Bus sequencer
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= emb_pkg::EMB_IDLE;
			cnt_q <= 6'h00;
		end else begin
			unique case (state_q)
				emb_pkg::EMB_IDLE: begin
					if (grant_go) begin
						state_q <= emb_pkg::EMB_HOLD;
					end else if (start_go) begin
						state_q <= emb_pkg::EMB_SETUP;
						cnt_q <= stb_len;
					end
				end
				emb_pkg::EMB_SETUP: begin
					state_q <= emb_pkg::EMB_STROBE;
				end
				emb_pkg::EMB_STROBE: begin
					if (cnt_q == 6'h00) begin
						state_q <= emb_pkg::EMB_RECOV;
					end else begin
						cnt_q <= cnt_q - 6'h01;
					end
				end
				emb_pkg::EMB_RECOV: begin
					if (ph_q == emb_pkg::PH_LAST) begin
						state_q <= emb_pkg::EMB_IDLE;
					end
				end
				emb_pkg::EMB_HOLD: begin
					if (req_sync_n) begin
						state_q <= emb_pkg::EMB_UNHOLD;
					end
				end
				emb_pkg::EMB_UNHOLD: begin
					state_q <= emb_pkg::EMB_IDLE;
				end
				default: begin
					state_q <= emb_pkg::EMB_IDLE;
				end
			endcase
		end
	end

	// Hold acknowledge and control driver enable
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			hold_ack_n <= 1'b1;
			ctrl_oe <= 1'b1;
		end else if (grant_go) begin
			hold_ack_n <= 1'b0;
			ctrl_oe <= 1'b0;
		end else if ((state_q == emb_pkg::EMB_HOLD) && req_sync_n) begin
			hold_ack_n <= 1'b1;
		end else if (state_q == emb_pkg::EMB_UNHOLD) begin
			ctrl_oe <= 1'b1;
		end
	end

	// Access attributes latched at start
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			write_q <= 1'b0;
			space_q <= emb_pkg::SPACE_DATA;
			mem_addr <= '0;
			mem_data_out <= '0;
		end else if (start_go) begin
			write_q <= acc_write;
			space_q <= acc_space;
			mem_addr <= acc_addr;
			mem_data_out <= acc_wdata;
		end
	end

	// One select flop per memory space
	genvar gi;
	generate
		for (gi = 0; gi < emb_pkg::NUM_SPACES; gi++) begin : g_sel
			always_ff @(posedge sys_clk or negedge arst_n) begin
				if (!arst_n) begin
					space_select_n[gi] <= 1'b1;
				end else if (start_go) begin
					space_select_n[gi] <= (acc_space != 2'(gi));
				end else if ((state_q == emb_pkg::EMB_RECOV) && (ph_q == emb_pkg::PH_LAST)) begin
					space_select_n[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	// Read and write strobes
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			read_strobe_n <= 1'b1;
			write_strobe_n <= 1'b1;
		end else if (state_q == emb_pkg::EMB_SETUP) begin
			read_strobe_n <= write_q;
			write_strobe_n <= ~write_q;
		end else if (stb_end) begin
			read_strobe_n <= 1'b1;
			write_strobe_n <= 1'b1;
		end
	end

	// Write data driver
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_data_oe <= 1'b0;
		end else if ((state_q == emb_pkg::EMB_STROBE) && write_q && !write_strobe_n && !stb_end) begin
			mem_data_oe <= 1'b1;
		end else if (state_q != emb_pkg::EMB_STROBE) begin
			mem_data_oe <= 1'b0;
		end
	end

	// Read capture at strobe rise and completion pulse
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_rdata <= '0;
			acc_done <= 1'b0;
		end else begin
			acc_done <= stb_end;
			if (stb_end && !write_q) begin
				acc_rdata <= mem_data_in;
			end
		end
	end
endmodule
`default_nettype wire

// ===== dv/emb_bus_assertions.sv
// Checker for the external memory bus ports
`timescale 1ns/1ps
`default_nettype none
module emb_bus_chk (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [1:0] acc_space,
	input wire logic [2:0] wait_prog,
	input wire logic [2:0] wait_data,
	input wire logic [2:0] wait_boot,
	input wire logic hold_request_n,
	input wire logic hold_ack_n,
	input wire logic [2:0] space_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic ctrl_oe,
	input wire logic mem_data_oe
);
	logic [5:0] low_q;
	logic [2:0] ws;
	logic stb;
	assign stb = read_strobe_n & write_strobe_n;
	assign ws = acc_space == 2'h0 ? wait_prog : acc_space == 2'h1 ? wait_data : wait_boot;
	// Counts cycles with a strobe low
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			low_q <= 6'h00;
		end else begin
			low_q <= stb ? 6'h00 : low_q + 6'h01;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	a_grant_float: assert property ($fell(hold_ack_n) |-> !ctrl_oe)
		else $error("drivers on at grant");
	a_release_order: assert property ($rose(ctrl_oe) |-> hold_ack_n)
		else $error("drivers on before release");
	a_ack_latency: assert property ($fell(hold_ack_n) |-> !$past(hold_request_n, 4))
		else $error("grant too early");
	a_ack_bound: assert property ($fell(hold_request_n) |-> ##[1:80] !hold_ack_n)
		else $error("grant missing");
	a_wdata_late: assert property ($rose(mem_data_oe) |-> !write_strobe_n)
		else $error("data before strobe");
	a_wdata_lead: assert property ($rose(write_strobe_n) |-> mem_data_oe && $past(mem_data_oe))
		else $error("data not ahead of strobe rise");
	a_data_release: assert property ($fell(read_strobe_n) || $fell(write_strobe_n) |-> !mem_data_oe)
		else $error("data still driven");
	a_strobe_width: assert property ($rose(stb) |-> low_q == 6'h02 + {1'b0, ws, 2'b00})
		else $error("strobe width wrong");
	a_one_select: assert property ($countones(~space_select_n) <= 1)
		else $error("several selects");
endmodule
bind emb_bus emb_bus_chk u_chk (.sys_clk, .arst_n, .acc_space, .wait_prog, .wait_data,
	.wait_boot, .hold_request_n, .hold_ack_n, .space_select_n, .read_strobe_n,
	.write_strobe_n, .ctrl_oe, .mem_data_oe);
`default_nettype wire

// ===== dv/emb_mem_model.sv
// Asynchronous external memory model
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
	input wire logic [13:0] mem_addr,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [23:0] mem_data_out,
	input wire logic mem_data_oe,
	output logic [23:0] mem_data_in
);
	logic [23:0] mem [0:16383];
	always @(posedge write_strobe_n) if (mem_data_oe) mem[mem_addr] = mem_data_out;
	// Data valid while read strobe low, inverted once released
	assign mem_data_in = read_strobe_n ? ~mem[mem_addr] : mem[mem_addr];
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the external memory bus
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin \
	n_checks++; \
	if ((a) !== (b)) begin \
		bad_count++; \
		$display("CHECK FAILED %0t %h %h", $time, (a), (b)); \
	end \
end
module tb;
	logic sys_clk = 0, arst_n = 0, acc_req = 0, acc_write = 0, hold_request_n = 1;
	logic [1:0] acc_space = 0;
	logic [13:0] acc_addr = 0, mem_addr;
	logic [23:0] acc_wdata = 0, acc_rdata, mem_data_in, mem_data_out;
	logic [2:0] wait_prog = 0, wait_data = 0, wait_boot = 0, space_select_n;
	logic acc_done, cycle_clock_out, hold_ack_n, read_strobe_n, write_strobe_n, ctrl_oe;
	logic mem_data_oe;
	logic [23:0] ref_m [int];
	logic [13:0] aq [12];
	int bad_count = 0, n_checks = 0;
	int n_edges = 0;
	// Clock edges since reset release, reference for the cycle clock
	always @(posedge sys_clk) begin
		if (arst_n) begin
			n_edges <= n_edges + 1;
		end
	end
	emb_bus dut (.sys_clk, .arst_n, .acc_req, .acc_write, .acc_space, .acc_addr, .acc_wdata,
		.wait_prog, .wait_data, .wait_boot, .acc_done, .acc_rdata, .cycle_clock_out,
		.hold_request_n, .hold_ack_n, .mem_addr, .space_select_n, .read_strobe_n,
		.write_strobe_n, .ctrl_oe, .mem_data_in, .mem_data_out, .mem_data_oe);
	emb_mem_model mem (.mem_addr, .read_strobe_n, .write_strobe_n, .mem_data_out,
		.mem_data_oe, .mem_data_in);
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [1:0] sp, input logic [13:0] a);
		int n, lo;
		logic [2:0] sel, ws;
		n = 0;
		lo = 0;
		sel = 0;
		@(negedge sys_clk);
		{acc_req, acc_write, acc_space, acc_addr} = {1'b1, w, sp, a};
		{wait_prog, wait_data, wait_boot} = 9'($urandom);
		ws = sp == 2'h0 ? wait_prog : sp == 2'h1 ? wait_data : wait_boot;
		acc_wdata = 24'($urandom);
		if (w) ref_m[a] = acc_wdata;
		while (acc_done !== 1'b1 && n < 200) begin
			@(negedge sys_clk);
			n++;
			lo += !(read_strobe_n & write_strobe_n);
			sel |= ~space_select_n;
			`CK(cycle_clock_out, (n_edges % 4 < 2))
		end
		acc_req = 0;
		`CK(acc_done, 1'b1)
		`CK(lo, 2 + 4 * ws)
		`CK(sel, 3'h1 << sp)
		if (!w) `CK(acc_rdata, ref_m[a])
	endtask
	task automatic hold();
		int n;
		n = 0;
		@(negedge sys_clk);
		hold_request_n = 0;
		while (hold_ack_n !== 1'b0 && n < 100) begin @(negedge sys_clk); n++; end
		`CK(hold_ack_n, 1'b0)
		`CK(ctrl_oe, 1'b0)
		repeat (5) @(negedge sys_clk);
		hold_request_n = 1;
		while (hold_ack_n !== 1'b1 && n < 200) begin @(negedge sys_clk); n++; end
		`CK(hold_ack_n, 1'b1)
		`CK(ctrl_oe, 1'b0)
		@(negedge sys_clk);
		`CK(ctrl_oe, 1'b1)
	endtask
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		#100000;
		bad_count++;
		give_verdict();
	end
	initial begin
		void'($urandom(32'h2a90));
		repeat (4) @(negedge sys_clk);
		arst_n = 1;
		for (int i = 0; i < 12; i++) begin
			aq[i] = 14'($urandom);
			acc(1'b1, 2'(i % 3), aq[i]);
		end
		for (int i = 0; i < 12; i++) acc(1'b0, 2'(i % 3), aq[i]);
		$display("test accesses done");
		hold();
		fork
			acc(1'b0, 2'h1, aq[1]);
			hold();
		join
		$display("test hold done");
		give_verdict();
	end
endmodule
`default_nettype wire
